// ===== common/mfr_pkg.sv
// Constants, states and shared helpers of the multi-line fast read path.
// Assumes a serial clock domain at the link and a system clock domain.
package mfr_pkg;

   // --------------------------------------------------------------
   // Instruction codes
   // --------------------------------------------------------------
   localparam logic [7:0] OP_DUAL_OUT    = 8'h3B;
   localparam logic [7:0] OP_DUAL_OUT_4B = 8'h3C;
   localparam logic [7:0] OP_QUAD_OUT    = 8'h6B;
   localparam logic [7:0] OP_QUAD_OUT_4B = 8'h6C;
   localparam logic [7:0] OP_DUAL_IO     = 8'hBB;
   localparam logic [7:0] OP_DUAL_IO_4B  = 8'hBC;
   localparam logic [7:0] OP_QUAD_IO     = 8'hEB;
   localparam logic [7:0] OP_WRAP_SET    = 8'h77;
   localparam logic [7:0] OP_ENTER_4B    = 8'hB7;
   localparam logic [7:0] OP_EXIT_4B     = 8'hE9;

   // --------------------------------------------------------------
   // Phase lengths in serial clocks, address and byte lengths in bits, lane widths as log2
   // --------------------------------------------------------------
   localparam logic [5:0] OPCODE_CLOCKS   = 6'h08;
   localparam logic [5:0] DUMMY_OUT       = 6'h08;
   localparam logic [5:0] DUMMY_DUAL_IO   = 6'h04;
   localparam logic [5:0] DUMMY_QUAD_IO   = 6'h06;
   localparam logic [5:0] WRAP_ARG_CLOCKS = 6'h02;
   localparam logic [5:0] ADDR_BITS_3B    = 6'h18;
   localparam logic [5:0] ADDR_BITS_4B    = 6'h20;
   localparam logic [5:0] BYTE_BITS       = 6'h08;
   localparam logic [1:0] LANE_ONE        = 2'h0;
   localparam logic [1:0] LANE_TWO        = 2'h1;
   localparam logic [1:0] LANE_FOUR       = 2'h2;

   // --------------------------------------------------------------
   // Wrap setting byte layout and reset values
   // --------------------------------------------------------------
   localparam int         WRAP_DIS_POS    = 4;
   localparam int         WRAP_LEN_LSB    = 5;
   localparam logic       WRAP_DIS_RESET  = 1'b1;
   localparam logic [1:0] WRAP_LEN_RESET  = 2'h0;
   localparam logic       FOUR_BYTE_RESET = 1'b0;
   localparam logic [31:0] WRAP_BASE_SIZE = 32'h0000_0008;

   typedef enum logic [2:0] {
      ST_OPCODE   = 3'b000,
      ST_ADDR     = 3'b001,
      ST_DUMMY    = 3'b010,
      ST_DATA     = 3'b011,
      ST_WRAP_ARG = 3'b100,
      ST_IDLE     = 3'b101
   } mfr_state_e;

   typedef enum logic [1:0] {
      EV_ENTER_4B = 2'b00,
      EV_EXIT_4B  = 2'b01,
      EV_WRAP     = 2'b10
   } mfr_event_e;

   // Shift new line bits in at the bottom, highest line as most significant
   function automatic logic [31:0] shift_lanes(input logic [31:0] old,
                                               input logic [3:0]  lines,
                                               input logic [1:0]  lane_log);
      logic [31:0] res;
      res = {old[30:0], lines[0]};
      if (lane_log == LANE_TWO) begin
         res = {old[29:0], lines[1:0]};
      end else if (lane_log == LANE_FOUR) begin
         res = {old[27:0], lines};
      end
      return res;
   endfunction : shift_lanes

endpackage : mfr_pkg

// ===== hdl/mfr_sync.sv
// Two-flop level synchroniser.
// Assumes the input is a level held stable over several destination clocks.
`timescale 1ns/10ps
module mfr_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock
   input  wire logic             clk,
   // Level in and synchronised level out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk) begin
      meta <= d;
      q    <= meta;
   end
endmodule : mfr_sync

// ===== hdl/mfr_addr_step.sv
// Next read address, confined to the wrap section when wrapping is on.
// Purely combinational; caller registers the result.
`timescale 1ns/10ps
module mfr_addr_step (
   // Current address and wrap setting
   input  wire logic [31:0] addr,
   input  wire logic        wrap_on,
   input  wire logic [1:0]  wrap_length_field,
   // Following address
   output logic      [31:0] step_addr
);
   logic [31:0] mask;
   logic [31:0] inc;

   always_comb begin
      mask = (mfr_pkg::WRAP_BASE_SIZE << wrap_length_field) - 32'h0000_0001;
      inc  = addr + 32'h0000_0001;
      if (wrap_on) begin
         step_addr = (addr & ~mask) | (inc & mask);
      end else begin
         step_addr = inc;
      end
   end
endmodule : mfr_addr_step

// ===== hdl/mfr_fast_read.sv
// Dual and quad fast read command path of a serial flash die.
// Assumes the host drives chip select and the serial clock, and that the
// array answers mem_rdata for mem_addr within half a serial clock.
`timescale 1ns/10ps
module mfr_fast_read (
   // System clock domain
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  ext_address_byte,
   // Link clock and select
   input  wire logic        serial_clock,
   input  wire logic        chip_select_n,
   // Serial line zero
   input  wire logic        serial_line_zero_in,
   output logic             serial_line_zero_out,
   output logic             serial_line_zero_oe,
   // Serial line one
   input  wire logic        serial_line_one_in,
   output logic             serial_line_one_out,
   output logic             serial_line_one_oe,
   // Serial line two
   input  wire logic        serial_line_two_in,
   output logic             serial_line_two_out,
   output logic             serial_line_two_oe,
   // Serial line three
   input  wire logic        serial_line_three_in,
   output logic             serial_line_three_out,
   output logic             serial_line_three_oe,
   // Array read port, link domain
   output logic      [31:0] mem_addr,
   input  wire logic [7:0]  mem_rdata,
   // Mode state, system domain
   output logic             four_byte_mode,
   output logic             wrap_disable_bit,
   output logic      [1:0]  wrap_length_field
);

   // ------------------------------------------------------------------
   // Link-side declarations
   // ------------------------------------------------------------------
   mfr_pkg::mfr_state_e state;
   mfr_pkg::mfr_state_e next_state;
   mfr_pkg::mfr_event_e ev_kind;
   mfr_pkg::mfr_event_e next_ev_kind;
   logic [5:0]  cnt;
   logic [5:0]  next_cnt;
   logic [31:0] shreg;
   logic [31:0] next_shreg;
   logic [31:0] shifted;
   logic [31:0] addr;
   logic [31:0] next_addr;
   logic [31:0] step_addr;
   logic [1:0]  addr_lane;
   logic [1:0]  next_addr_lane;
   logic [1:0]  data_lane;
   logic [1:0]  next_data_lane;
   logic [1:0]  cur_lane;
   logic [5:0]  addr_bits;
   logic [5:0]  next_addr_bits;
   logic [5:0]  dummy;
   logic [5:0]  next_dummy;
   logic        wrap_read;
   logic        next_wrap_read;
   logic        wrap_cmd;
   logic        next_wrap_cmd;
   logic        tog;
   logic        next_tog;
   logic [2:0]  ev_wrap;
   logic [2:0]  next_ev_wrap;
   logic [3:0]  lines_in;
   logic [3:0]  lines_out;
   logic [3:0]  next_lines_out;
   logic [3:0]  lines_oe;
   logic [3:0]  next_lines_oe;
   logic [7:0]  slice;
   logic [11:0] link_cfg;

   // ------------------------------------------------------------------
   // System-side declarations
   // ------------------------------------------------------------------
   logic        link_rst;
   logic        tog_sync;
   logic        tog_seen;
   logic        next_tog_seen;
   logic        next_four_byte;
   logic        next_wrap_dis;
   logic [1:0]  next_wrap_len;
   logic [11:0] sys_cfg;

   assign lines_in = {serial_line_three_in, serial_line_two_in,
                      serial_line_one_in, serial_line_zero_in};
   assign mem_addr = addr;

   // ------------------------------------------------------------------
   // Crossings: settings into the link, command event into the system
   // ------------------------------------------------------------------
   mfr_sync #(
      .WIDTH (12)
   ) u_cfg_sync (
      .clk (serial_clock),
      .d   (sys_cfg),
      .q   (link_cfg)
   );

   mfr_sync #(
      .WIDTH (1)
   ) u_tog_sync (
      .clk (clk),
      .d   (tog),
      .q   (tog_sync)
   );

   mfr_addr_step u_step (
      .addr              (addr),
      .wrap_on           (wrap_read & ~link_cfg[10]),
      .wrap_length_field (link_cfg[9:8]),
      .step_addr         (step_addr)
   );

   // ------------------------------------------------------------------
   // Command sequencer, sampled on the rising serial clock
   // ------------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_cnt       = cnt + 6'h01;
      next_addr      = addr;
      next_addr_lane = addr_lane;
      next_data_lane = data_lane;
      next_addr_bits = addr_bits;
      next_dummy     = dummy;
      next_wrap_read = wrap_read;
      next_wrap_cmd  = wrap_cmd;
      next_tog       = tog;
      next_ev_kind   = ev_kind;
      next_ev_wrap   = ev_wrap;
      cur_lane       = mfr_pkg::LANE_ONE;
      if (state == mfr_pkg::ST_ADDR) begin
         cur_lane = addr_lane;
      end else if (state == mfr_pkg::ST_WRAP_ARG) begin
         cur_lane = mfr_pkg::LANE_FOUR;
      end
      shifted    = mfr_pkg::shift_lanes(shreg, lines_in, cur_lane);
      next_shreg = shifted;
      case (state)
         mfr_pkg::ST_OPCODE: begin
            if (cnt == mfr_pkg::OPCODE_CLOCKS - 6'h01) begin
               next_cnt       = 6'h00;
               next_state     = mfr_pkg::ST_ADDR;
               next_addr_bits = link_cfg[11] ? mfr_pkg::ADDR_BITS_4B
                                             : mfr_pkg::ADDR_BITS_3B;
               next_addr_lane = mfr_pkg::LANE_ONE;
               next_data_lane = mfr_pkg::LANE_TWO;
               next_dummy     = mfr_pkg::DUMMY_OUT;
               next_wrap_read = 1'b0;
               next_wrap_cmd  = 1'b0;
               case (shifted[7:0])
                  mfr_pkg::OP_DUAL_OUT: begin
                     next_data_lane = mfr_pkg::LANE_TWO;
                  end
                  mfr_pkg::OP_DUAL_OUT_4B: begin
                     next_addr_bits = mfr_pkg::ADDR_BITS_4B;
                  end
                  mfr_pkg::OP_QUAD_OUT: begin
                     next_data_lane = mfr_pkg::LANE_FOUR;
                  end
                  mfr_pkg::OP_QUAD_OUT_4B: begin
                     next_data_lane = mfr_pkg::LANE_FOUR;
                     next_addr_bits = mfr_pkg::ADDR_BITS_4B;
                  end
                  mfr_pkg::OP_DUAL_IO: begin
                     next_addr_lane = mfr_pkg::LANE_TWO;
                     next_dummy     = mfr_pkg::DUMMY_DUAL_IO;
                  end
                  mfr_pkg::OP_DUAL_IO_4B: begin
                     next_addr_lane = mfr_pkg::LANE_TWO;
                     next_dummy     = mfr_pkg::DUMMY_DUAL_IO;
                     next_addr_bits = mfr_pkg::ADDR_BITS_4B;
                  end
                  mfr_pkg::OP_QUAD_IO: begin
                     next_addr_lane = mfr_pkg::LANE_FOUR;
                     next_data_lane = mfr_pkg::LANE_FOUR;
                     next_dummy     = mfr_pkg::DUMMY_QUAD_IO;
                     next_wrap_read = 1'b1;
                  end
                  mfr_pkg::OP_WRAP_SET: begin
                     next_addr_lane = mfr_pkg::LANE_FOUR;
                     next_wrap_cmd  = 1'b1;
                  end
                  mfr_pkg::OP_ENTER_4B: begin
                     next_state   = mfr_pkg::ST_IDLE;
                     next_ev_kind = mfr_pkg::EV_ENTER_4B;
                     next_tog     = ~tog;
                  end
                  mfr_pkg::OP_EXIT_4B: begin
                     next_state   = mfr_pkg::ST_IDLE;
                     next_ev_kind = mfr_pkg::EV_EXIT_4B;
                     next_tog     = ~tog;
                  end
                  default: begin
                     next_state = mfr_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         mfr_pkg::ST_ADDR: begin
            if (cnt == (addr_bits >> addr_lane) - 6'h01) begin
               next_cnt   = 6'h00;
               next_state = wrap_cmd ? mfr_pkg::ST_WRAP_ARG : mfr_pkg::ST_DUMMY;
               if (addr_bits == mfr_pkg::ADDR_BITS_4B) begin
                  next_addr = shifted;
               end else begin
                  next_addr = {link_cfg[7:0], shifted[23:0]};
               end
            end
         end
         mfr_pkg::ST_DUMMY: begin
            if (cnt == dummy - 6'h01) begin
               next_cnt   = 6'h00;
               next_state = mfr_pkg::ST_DATA;
            end
         end
         mfr_pkg::ST_DATA: begin
            if (cnt == (mfr_pkg::BYTE_BITS >> data_lane) - 6'h01) begin
               next_cnt  = 6'h00;
               next_addr = step_addr;
            end
         end
         mfr_pkg::ST_WRAP_ARG: begin
            if (cnt == mfr_pkg::WRAP_ARG_CLOCKS - 6'h01) begin
               next_state   = mfr_pkg::ST_IDLE;
               next_ev_kind = mfr_pkg::EV_WRAP;
               next_ev_wrap = shifted[mfr_pkg::WRAP_LEN_LSB+1:mfr_pkg::WRAP_DIS_POS];
               next_tog     = ~tog;
            end
         end
         default: begin
            next_cnt = cnt;
         end
      endcase
   end

   always_ff @(posedge serial_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         state     <= mfr_pkg::ST_OPCODE;
         cnt       <= 6'h00;
         shreg     <= 32'h0000_0000;
         addr      <= 32'h0000_0000;
         addr_lane <= mfr_pkg::LANE_ONE;
         data_lane <= mfr_pkg::LANE_TWO;
         addr_bits <= mfr_pkg::ADDR_BITS_3B;
         dummy     <= mfr_pkg::DUMMY_OUT;
         wrap_read <= 1'b0;
         wrap_cmd  <= 1'b0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         shreg     <= next_shreg;
         addr      <= next_addr;
         addr_lane <= next_addr_lane;
         data_lane <= next_data_lane;
         addr_bits <= next_addr_bits;
         dummy     <= next_dummy;
         wrap_read <= next_wrap_read;
         wrap_cmd  <= next_wrap_cmd;
      end
   end

   // Event toggle survives deselect; only system reset clears it
   always_ff @(posedge serial_clock or posedge link_rst) begin
      if (link_rst) begin
         tog <= 1'b0;
      end else begin
         tog <= next_tog;
      end
   end

   // Event payload is read by the system side only after the toggle moves
   always_ff @(posedge serial_clock) begin
      ev_kind <= next_ev_kind;
      ev_wrap <= next_ev_wrap;
   end

   // ------------------------------------------------------------------
   // Data driver, launched on the falling serial clock
   // ------------------------------------------------------------------
   always_comb begin
      slice          = mem_rdata << (cnt[2:0] << data_lane);
      next_lines_out = 4'h0;
      next_lines_oe  = 4'h0;
      if (state == mfr_pkg::ST_DATA) begin
         if (data_lane == mfr_pkg::LANE_FOUR) begin
            next_lines_out = slice[7:4];
            next_lines_oe  = 4'hF;
         end else begin
            next_lines_out = {2'h0, slice[7:6]};
            next_lines_oe  = 4'h3;
         end
      end
   end

   always_ff @(negedge serial_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         lines_out <= 4'h0;
         lines_oe  <= 4'h0;
      end else begin
         lines_out <= next_lines_out;
         lines_oe  <= next_lines_oe;
      end
   end

   assign serial_line_zero_out  = lines_out[0];
   assign serial_line_one_out   = lines_out[1];
   assign serial_line_two_out   = lines_out[2];
   assign serial_line_three_out = lines_out[3];
   assign serial_line_zero_oe   = lines_oe[0];
   assign serial_line_one_oe    = lines_oe[1];
   assign serial_line_two_oe    = lines_oe[2];
   assign serial_line_three_oe  = lines_oe[3];

   // ------------------------------------------------------------------
   // Mode state in the system domain
   // ------------------------------------------------------------------
   always_comb begin
      next_tog_seen  = tog_sync;
      next_four_byte = four_byte_mode;
      next_wrap_dis  = wrap_disable_bit;
      next_wrap_len  = wrap_length_field;
      if (tog_sync != tog_seen) begin
         case (ev_kind)
            mfr_pkg::EV_ENTER_4B: begin
               next_four_byte = 1'b1;
            end
            mfr_pkg::EV_EXIT_4B: begin
               next_four_byte = 1'b0;
            end
            default: begin
               next_wrap_dis = ev_wrap[0];
               next_wrap_len = ev_wrap[2:1];
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      link_rst <= reset;
      sys_cfg  <= {four_byte_mode, wrap_disable_bit, wrap_length_field, ext_address_byte};
      if (reset) begin
         tog_seen          <= 1'b0;
         four_byte_mode    <= mfr_pkg::FOUR_BYTE_RESET;
         wrap_disable_bit  <= mfr_pkg::WRAP_DIS_RESET;
         wrap_length_field <= mfr_pkg::WRAP_LEN_RESET;
      end else begin
         tog_seen          <= next_tog_seen;
         four_byte_mode    <= next_four_byte;
         wrap_disable_bit  <= next_wrap_dis;
         wrap_length_field <= next_wrap_len;
      end
   end

endmodule : mfr_fast_read

// ===== dv/mfr_checker.sv
// Concurrent checks on the fast read block ports.
// Assumes binding to mfr_fast_read; link sequencer and line drivers are cleared while select is high, the event toggle is not.
`timescale 1ns/10ps
module mfr_checker (
   // Clocks and selects
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        serial_clock,
   input wire logic        chip_select_n,
   // Lines
   input wire logic        serial_line_zero_in,
   input wire logic        serial_line_zero_oe,
   input wire logic        serial_line_one_oe,
   input wire logic        serial_line_two_oe,
   input wire logic        serial_line_three_oe,
   // Array address and mode
   input wire logic [31:0] mem_addr,
   input wire logic        four_byte_mode,
   input wire logic        wrap_disable_bit,
   input wire logic [1:0]  wrap_length_field
);
   logic [6:0]  cnt, next_cnt, st;
   logic [7:0]  op, next_op;
   logic [3:0]  oe;
   logic [31:0] msk;
   logic        wr;
   always_comb begin
      next_cnt = (cnt == 7'h7F) ? cnt : cnt + 7'h01;
      next_op = (cnt < 7'h08) ? {op[6:0], serial_line_zero_in} : op;
   end
   always_ff @(posedge serial_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         cnt <= 7'h00;
         op <= 8'h00;
      end else begin
         cnt <= next_cnt;
         op <= next_op;
      end
   end
   // Rising clocks that pass before the first data sample
   always_comb begin
      case (op)
         8'h3B, 8'h6B: st = four_byte_mode ? 7'h30 : 7'h28;
         8'h3C, 8'h6C: st = 7'h30;
         8'hBB: st = four_byte_mode ? 7'h1C : 7'h18;
         8'hBC: st = 7'h1C;
         8'hEB: st = four_byte_mode ? 7'h16 : 7'h14;
         default: st = 7'h7F;
      endcase
   end
   assign oe = {serial_line_three_oe, serial_line_two_oe, serial_line_one_oe, serial_line_zero_oe};
   assign msk = (32'h8 << wrap_length_field) - 32'h1;
   assign wr = (op == 8'hEB) && !wrap_disable_bit;
   sequence s_dummy_done;
      (st != 7'h7F) && (cnt == st);
   endsequence
   sequence s_stepped;
      (st != 7'h7F) && (cnt > st + 7'h01) && $changed(mem_addr);
   endsequence
   a_oe_deselect: assert property (@(posedge clk) disable iff (reset)
      chip_select_n |-> oe == 4'h0) else $error("line driven while deselected");
   a_reset_vals: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> !four_byte_mode && wrap_disable_bit && wrap_length_field == 2'h0)
      else $error("mode bits not at reset values");
   a_dual_width: assert property (
      @(posedge serial_clock) disable iff (chip_select_n)
      op inside {8'h3B, 8'h3C, 8'hBB, 8'hBC} && cnt > 7'h08 && oe[0] |-> oe == 4'h3)
      else $error("dual read drives wrong lines");
   a_quad_width: assert property (
      @(posedge serial_clock) disable iff (chip_select_n)
      op inside {8'h6B, 8'h6C, 8'hEB} && cnt > 7'h08 && oe[0] |-> oe == 4'hF)
      else $error("quad read drives wrong lines");
   a_data_start: assert property (
      @(posedge serial_clock) disable iff (chip_select_n)
      $rose(oe[0]) |-> cnt == st) else $error("data started at wrong clock");
   a_data_held: assert property (
      @(posedge serial_clock) disable iff (chip_select_n)
      s_dummy_done |-> oe[0] ##1 oe[0]) else $error("data not driven after dummy");
   a_addr_step: assert property (@(posedge serial_clock) disable iff (chip_select_n)
      s_stepped |-> wr || mem_addr == $past(mem_addr) + 32'h1)
      else $error("read address did not advance by one");
   a_wrap_bound: assert property (@(posedge serial_clock) disable iff (chip_select_n)
      s_stepped |-> !wr || (((mem_addr ^ ($past(mem_addr) + 32'h1)) & msk) == 32'h0
      && ((mem_addr ^ $past(mem_addr)) & ~msk) == 32'h0)) else $error("wrap left its section");
endmodule : mfr_checker

bind mfr_fast_read mfr_checker u_chk (.clk(clk), .reset(reset), .serial_clock(serial_clock),
   .chip_select_n(chip_select_n), .serial_line_zero_in(serial_line_zero_in),
   .serial_line_zero_oe(serial_line_zero_oe), .serial_line_one_oe(serial_line_one_oe),
   .serial_line_two_oe(serial_line_two_oe), .serial_line_three_oe(serial_line_three_oe),
   .mem_addr(mem_addr), .four_byte_mode(four_byte_mode), .wrap_disable_bit(wrap_disable_bit),
   .wrap_length_field(wrap_length_field));

// ===== dv/mfr_host_model.sv
// Host controller model: select, serial clock and the four lines.
// Assumes clock idles low; an undriven line toggles so stale data never matches.
`timescale 1ns/10ps
module mfr_host_model (
   // Link clock and select
   output logic            serial_clock,
   output logic            chip_select_n,
   // Line levels and device drive
   output logic      [3:0] lvl,
   input  wire logic [3:0] dev_out,
   input  wire logic [3:0] dev_oe
);
   logic [3:0] h_val = 4'h0;
   logic [3:0] h_oe = 4'h0;
   logic [3:0] flt = 4'h5;
   // Select rises after time zero so the link and checker resets see a clean edge
   initial begin
      serial_clock = 1'b0;
      chip_select_n = 1'b0;
      #1 chip_select_n = 1'b1;
   end
   always @(serial_clock) flt = ~flt;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lvl[i] = dev_oe[i] ? dev_out[i] : (h_oe[i] ? h_val[i] : flt[i]);
      end
   end
   task automatic pulse();
      #62.5 serial_clock = 1'b1;
      #62.5 serial_clock = 1'b0;
   endtask : pulse
   task automatic open_frame();
      chip_select_n = 1'b0;
   endtask : open_frame
   task automatic close_frame();
      chip_select_n = 1'b1;
      h_oe = 4'h0;
      #300;
   endtask : close_frame
   // Most significant first, highest line carrying the top bit
   task automatic send(input logic [31:0] val, input int nbits, input int lanes);
      h_oe = (4'h1 << lanes) - 4'h1;
      for (int b = nbits - lanes; b >= 0; b -= lanes) begin
         h_val = 4'(val >> b) & h_oe;
         pulse();
      end
   endtask : send
   task automatic dummy(input int n);
      for (int i = 0; i < n; i++) begin
         h_val = 4'($urandom);
         if (i == n - 1) h_oe = 4'h0;
         pulse();
      end
   endtask : dummy
   task automatic recv(input int nbytes, input int lanes, output logic [7:0] q[$]);
      logic [7:0] b;
      q = {};
      for (int k = 0; k < nbytes; k++) begin
         for (int j = 0; j < 8 / lanes; j++) begin
            #62.5 serial_clock = 1'b1;
            b = (b << lanes) | 8'(lvl & ((4'h1 << lanes) - 4'h1));
            #62.5 serial_clock = 1'b0;
         end
         q.push_back(b);
      end
   endtask : recv
endmodule : mfr_host_model

// ===== dv/testbench.sv
// Self-checking bench: host model, scrambled array and a reference model.
// Assumes package, design, host model and checker compiled before it.
`timescale 1ns/10ps
module testbench;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  ext = 8'h00;
   logic        sclk, csn, fb, dis, fbm, dism;
   logic [3:0]  lvl, dout, doe;
   logic [1:0]  len, lenm;
   logic [31:0] mem_addr;
   logic [7:0]  ops [7] = '{8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB};
   int          n_mismatch = 0;
   int          checks = 0;
   int          cyc = 0;
   function automatic logic [7:0] mem_byte(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ {a[19:16], a[31:28]} ^ a[27:20] ^ 8'h5A;
   endfunction : mem_byte
   mfr_fast_read DUT (.clk(clk), .reset(reset), .ext_address_byte(ext),
      .serial_clock(sclk), .chip_select_n(csn),
      .serial_line_zero_in(lvl[0]), .serial_line_zero_out(dout[0]), .serial_line_zero_oe(doe[0]),
      .serial_line_one_in(lvl[1]), .serial_line_one_out(dout[1]), .serial_line_one_oe(doe[1]),
      .serial_line_two_in(lvl[2]), .serial_line_two_out(dout[2]), .serial_line_two_oe(doe[2]),
      .serial_line_three_in(lvl[3]), .serial_line_three_out(dout[3]),
      .serial_line_three_oe(doe[3]), .mem_addr(mem_addr), .mem_rdata(mem_byte(mem_addr)),
      .four_byte_mode(fb), .wrap_disable_bit(dis), .wrap_length_field(len));
   mfr_host_model host (.serial_clock(sclk), .chip_select_n(csn), .lvl(lvl), .dev_out(dout),
      .dev_oe(doe));
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   task automatic check_data(input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR read byte expected %h seen %h", exp, got);
      end
   endtask : check_data
   task automatic check_mode();
      checks++;
      if ({fb, dis, len} !== {fbm, dism, lenm}) begin
         n_mismatch++;
         $display("ERROR mode bits expected %h seen %h", {fbm, dism, lenm}, {fb, dis, len});
      end
   endtask : check_mode
   task automatic do_read(input logic [7:0] op, input int nb);
      int          al, dl, dm, ab;
      logic [31:0] a, ea, m;
      logic [7:0]  q[$];
      al = (op == 8'hBB || op == 8'hBC) ? 2 : (op == 8'hEB) ? 4 : 1;
      dl = (op inside {8'h3B, 8'h3C, 8'hBB, 8'hBC}) ? 2 : 4;
      dm = (al == 2) ? 4 : (al == 4) ? 6 : 8;
      ab = (fbm || op inside {8'h3C, 8'h6C, 8'hBC}) ? 32 : 24;
      @(posedge clk);
      #2 ext = 8'($urandom);
      a = $urandom;
      ea = (ab == 32) ? a : {ext, a[23:0]};
      m = (op == 8'hEB && !dism) ? (32'h8 << lenm) - 32'h1 : 32'hFFFF_FFFF;
      repeat (8) @(posedge clk);
      host.open_frame();
      host.send(32'(op), 8, 1);
      host.send(a, ab, al);
      host.dummy(dm);
      host.recv(nb, dl, q);
      host.close_frame();
      foreach (q[i]) check_data(mem_byte((ea & ~m) | ((ea + i) & m)), q[i]);
   endtask : do_read
   task automatic cmd(input logic [7:0] op, input logic [7:0] wb);
      host.open_frame();
      host.send(32'(op), 8, 1);
      if (op == 8'h77) begin
         host.send($urandom, fbm ? 32 : 24, 4);
         host.send(32'(wb), 8, 4);
         dism = wb[4];
         lenm = wb[6:5];
      end else fbm = (op == 8'hB7);
      host.close_frame();
   endtask : cmd
   initial begin
      void'($urandom(3091));
      fbm = 1'b0;
      dism = 1'b1;
      lenm = 2'h0;
      repeat (5) @(posedge clk);
      #2 reset = 1'b0;
      repeat (6) @(posedge clk);
      check_mode();
      for (int k = 0; k < 2; k++) begin
         foreach (ops[j]) do_read(ops[j], 5);
         cmd(k == 0 ? 8'hB7 : 8'hE9, 8'h00);
         check_mode();
      end
      for (int l = 0; l < 5; l++) begin
         if (l == 2) cmd(8'hB7, 8'h00);
         cmd(8'h77, {1'($urandom), 2'(l), l == 4, 4'($urandom)});
         check_mode();
         do_read(8'hEB, (8 << (l % 4)) + 3);
         do_read(8'h6B, 12);
      end
      @(posedge clk);
      #2 reset = 1'b1;
      repeat (3) @(posedge clk);
      #2 reset = 1'b0;
      fbm = 1'b0;
      dism = 1'b1;
      lenm = 2'h0;
      repeat (6) @(posedge clk);
      check_mode();
      do_read(8'hEB, 20);
      conclude();
   end
endmodule : testbench
